// ### rtl/cap_pkg.sv
package cap_pkg;
  localparam int CLK_NS      = 25;
  localparam int SYNC_STAGES = 2;
  localparam int NUM_MODES   = 5;
  // Mode 0..4 minimums in ns; missing recovery figures mean only the cycle limit applies
  localparam int T0_NS  [NUM_MODES] = '{600, 383, 240, 180, 120};
  localparam int T1_NS  [NUM_MODES] = '{70, 50, 30, 30, 25};
  localparam int T2_NS  [NUM_MODES] = '{165, 125, 100, 80, 70};
  localparam int T2I_NS [NUM_MODES] = '{0, 0, 0, 70, 25};
  localparam logic [2:0] ATTR_MODE = 3'h0;
  localparam logic [2:0] MAX_MODE  = 3'h4;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_MODE_LSB = 4;
  localparam int PIO_CS_BIT    = 3;
  localparam int ST_COR_LSB    = 8;
  localparam int ST_IO_BIT     = 16;

  localparam logic [10:0] COR_ADDR    = 11'h200;
  localparam logic [7:0]  COR_RESET   = 8'h00;
  localparam int          SOFT_RESET_BIT_BIT  = 7;
  localparam int          LEVEL_IRQ_BIT = 6;
  localparam logic [7:0]  COR_RSVD_MASK = 8'h30;
  localparam logic [5:0]  CFG_MEM_MAPPED   = 6'h00;
  localparam logic [5:0]  CFG_IO_ANY       = 6'h01;
  localparam logic [5:0]  CFG_IO_PRIMARY   = 6'h02;
  localparam logic [5:0]  CFG_IO_SECONDARY = 6'h03;

  typedef enum logic [1:0] {
    OP_ATTR_RD = 2'h0,
    OP_ATTR_WR = 2'h1,
    OP_PIO_RD  = 2'h2,
    OP_PIO_WR  = 2'h3
  } cap_op_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SETUP   = 4'h2,
    ST_ACTIVE  = 4'h4,
    ST_RECOVER = 4'h8
  } cap_state_t;

  typedef struct packed {
    logic        reg_n;
    logic        even_byte_select_n;
    logic        odd_byte_select_n;
    logic        oe_n;
    logic        we_n;
    logic [10:0] addr;
    logic        task_file_select_low_n;
    logic        task_file_select_high_n;
    logic [2:0]  device_register_address;
    logic        io_read_strobe_n;
    logic        io_write_strobe_n;
  } cap_pins_t;

  localparam cap_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 11'h000,
                                      1'b1, 1'b1, 3'h0, 1'b1, 1'b1};

  // Least time rounds up to whole clocks, never below one
  function automatic logic [7:0] cap_cyc(input int ns);
    int c;
    c = (ns + CLK_NS - 1) / CLK_NS;
    if (c < 1) c = 1;
    return c[7:0];
  endfunction : cap_cyc
endpackage : cap_pkg

// ### rtl/cap_sync.sv
`timescale 1ns/10ps
module cap_sync #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule : cap_sync

// ### rtl/cap_host.sv
`timescale 1ns/10ps
module cap_host (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Card pins
  output cap_pkg::cap_pins_t     pins,
  output logic      [15:0]       dd_out,
  output logic                   dd_oe,
  input  wire logic [15:0]       dd_in
);
  cap_pkg::cap_state_t state_q, state_d;
  cap_pkg::cap_op_t    op_q, op_d, new_op;
  cap_pkg::cap_pins_t  pins_d;
  logic [7:0]  cnt_q, cnt_d;
  logic [2:0]  mode_q, mode_d, new_mode;
  logic [10:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d, rdata_q, rdata_d, dd_out_d, dd_sync;
  logic [7:0]  cor_q, cor_d, attr_byte;
  logic [31:0] prdata_d;
  logic        err_q, err_d, dd_oe_d, idle, apb_wr, start, bad;
  logic [7:0]  rec_c, gap_c;

  cap_sync #(.W(16)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (dd_in),
    .dout    (dd_sync)
  );

  function automatic logic cap_mapped(input logic [7:0] a);
    return a == cap_pkg::REG_CTRL || a == cap_pkg::REG_ADDR || a == cap_pkg::REG_WDATA ||
           a == cap_pkg::REG_RDATA || a == cap_pkg::REG_STATUS;
  endfunction : cap_mapped

  function automatic cap_pkg::cap_pins_t cap_drive(input cap_pkg::cap_state_t st,
                                                   input cap_pkg::cap_op_t op,
                                                   input logic [10:0] a);
    cap_pkg::cap_pins_t p;
    logic act;
    p = cap_pkg::PINS_IDLE;
    act = (st == cap_pkg::ST_ACTIVE);
    if (st != cap_pkg::ST_IDLE) begin
      p.addr = a;
      p.device_register_address = a[2:0];
      // Odd lane never selected: attribute space is even bytes only
      if (!op[1]) begin
        p.reg_n              = 1'b0;
        p.even_byte_select_n = 1'b0;
        p.oe_n               = !(act && !op[0]);
        p.we_n               = !(act && op[0]);
      end else begin
        p.task_file_select_low_n  = a[cap_pkg::PIO_CS_BIT];
        p.task_file_select_high_n = !a[cap_pkg::PIO_CS_BIT];
        p.io_read_strobe_n        = !(act && !op[0]);
        p.io_write_strobe_n       = !(act && op[0]);
      end
    end
    return p;
  endfunction : cap_drive

  assign idle   = (state_q == cap_pkg::ST_IDLE);
  assign apb_wr = psel && penable && pwrite;
  assign start  = apb_wr && idle && paddr == cap_pkg::REG_CTRL;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !cap_mapped(paddr);
  assign new_op   = cap_pkg::cap_op_t'(pwdata[1:0]);
  assign new_mode = !new_op[1] ? cap_pkg::ATTR_MODE :
                    (pwdata[cap_pkg::CTRL_MODE_LSB +: 3] > cap_pkg::MAX_MODE) ? 3'h0 :
                    pwdata[cap_pkg::CTRL_MODE_LSB +: 3];
  // Odd attribute address, or an attribute write outside the configuration registers, never reaches the card
  assign bad = !new_op[1] && (addr_q[0] ||
               (new_op[0] && addr_q[10:3] != cap_pkg::COR_ADDR[10:3]));
  // Recovery long enough for both its own minimum and the total cycle time
  assign gap_c = cap_pkg::cap_cyc(cap_pkg::T0_NS[mode_q] - cap_pkg::T2_NS[mode_q]);
  assign rec_c = (cap_pkg::cap_cyc(cap_pkg::T2I_NS[mode_q]) > gap_c) ?
                 cap_pkg::cap_cyc(cap_pkg::T2I_NS[mode_q]) : gap_c;
  // Reserved index bits forced to zero on the way to the card
  assign attr_byte = (addr_q == cap_pkg::COR_ADDR) ?
                     (wdata_q[7:0] & ~cap_pkg::COR_RSVD_MASK) : wdata_q[7:0];

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    op_d     = op_q;
    mode_d   = mode_q;
    addr_d   = addr_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    err_d    = err_q;
    cor_d    = cor_q;
    prdata_d = prdata;
    if (psel && !penable) begin
      case (paddr)
        cap_pkg::REG_ADDR:   prdata_d = {21'h000000, addr_q};
        cap_pkg::REG_WDATA:  prdata_d = {16'h0000, wdata_q};
        cap_pkg::REG_RDATA:  prdata_d = {16'h0000, rdata_q};
        cap_pkg::REG_STATUS: prdata_d = {15'h0000, cor_q[5:0] != cap_pkg::CFG_MEM_MAPPED,
                                         cor_q, 6'h00, err_q, !idle};
        default:             prdata_d = 32'h00000000;
      endcase
    end
    // Operand registers are frozen while a card cycle runs
    if (apb_wr && idle && paddr == cap_pkg::REG_ADDR) addr_d = pwdata[10:0];
    if (apb_wr && idle && paddr == cap_pkg::REG_WDATA) wdata_d = pwdata[15:0];
    case (state_q)
      cap_pkg::ST_IDLE: begin
        if (start) begin
          err_d = bad;
          if (!bad) begin
            op_d    = new_op;
            mode_d  = new_mode;
            state_d = cap_pkg::ST_SETUP;
            cnt_d   = cap_pkg::cap_cyc(cap_pkg::T1_NS[new_mode]) - 8'h01;
          end
        end
      end
      cap_pkg::ST_SETUP: begin
        if (cnt_q == 8'h00) begin
          state_d = cap_pkg::ST_ACTIVE;
          // Extra clocks cover the input synchroniser delay
          cnt_d = cap_pkg::cap_cyc(cap_pkg::T2_NS[mode_q]) + 8'(cap_pkg::SYNC_STAGES) - 8'h01;
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      cap_pkg::ST_ACTIVE: begin
        // Fixed length: no ready input is ever waited on
        if (cnt_q == 8'h00) begin
          state_d = cap_pkg::ST_RECOVER;
          cnt_d   = rec_c - 8'h01;
          if (!op_q[0]) rdata_d = op_q[1] ? dd_sync : {8'h00, dd_sync[7:0]};
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      cap_pkg::ST_RECOVER: begin
        if (cnt_q == 8'h00) begin
          state_d = cap_pkg::ST_IDLE;
          if (op_q == cap_pkg::OP_ATTR_WR && addr_q == cap_pkg::COR_ADDR) begin
            cor_d = attr_byte;
          end
        end else begin
          cnt_d = cnt_q - 8'h01;
        end
      end
      default: state_d = cap_pkg::ST_IDLE;
    endcase
    pins_d   = cap_drive(state_d, op_d, addr_d);
    dd_oe_d  = op_d[0] && state_d != cap_pkg::ST_IDLE;
    dd_out_d = op_d[1] ? wdata_d : {8'h00, attr_byte};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= cap_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
      op_q    <= cap_pkg::OP_ATTR_RD;
      mode_q  <= 3'h0;
      addr_q  <= 11'h000;
      wdata_q <= 16'h0000;
      rdata_q <= 16'h0000;
      err_q   <= 1'b0;
      cor_q   <= cap_pkg::COR_RESET;
      prdata  <= 32'h00000000;
      pins    <= cap_pkg::PINS_IDLE;
      dd_out  <= 16'h0000;
      dd_oe   <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      op_q    <= op_d;
      mode_q  <= mode_d;
      addr_q  <= addr_d;
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      err_q   <= err_d;
      cor_q   <= cor_d;
      prdata  <= prdata_d;
      pins    <= pins_d;
      dd_out  <= dd_out_d;
      dd_oe   <= dd_oe_d;
    end
  end

  // Checking helpers
  logic [7:0] act_len_q, cyc_len_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_len_q <= 8'h00;
      cyc_len_q <= 8'h00;
    end else begin
      act_len_q <= (state_q == cap_pkg::ST_ACTIVE) ? act_len_q + 8'h01 : 8'h00;
      cyc_len_q <= (state_q == cap_pkg::ST_ACTIVE || state_q == cap_pkg::ST_RECOVER) ?
                   cyc_len_q + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  attr_read_pins_a: assert property (
    state_q == cap_pkg::ST_ACTIVE && op_q == cap_pkg::OP_ATTR_RD |->
    !pins.reg_n && !pins.oe_n && pins.we_n && !pins.even_byte_select_n)
    else $error("attribute read strobes wrong");
  recovery_release_a: assert property (
    state_q == cap_pkg::ST_RECOVER |-> pins.oe_n && pins.we_n &&
    pins.io_read_strobe_n && pins.io_write_strobe_n)
    else $error("strobe held during recovery");
  active_width_a: assert property (
    state_q == cap_pkg::ST_ACTIVE && state_d != cap_pkg::ST_ACTIVE |->
    act_len_q + 8'h01 >= cap_pkg::cap_cyc(cap_pkg::T2_NS[mode_q]))
    else $error("strobe active time too short");
  cycle_time_a: assert property (
    state_q == cap_pkg::ST_RECOVER && state_d == cap_pkg::ST_IDLE |->
    cyc_len_q + 8'h01 >= cap_pkg::cap_cyc(cap_pkg::T0_NS[mode_q]))
    else $error("cycle time too short");
  odd_refused_a: assert property (
    start && !new_op[1] && addr_q[0] |=> err_q && state_q == cap_pkg::ST_IDLE)
    else $error("odd attribute access not refused");
  cfg_write_only_a: assert property (
    !pins.we_n |-> pins.addr[10:3] == cap_pkg::COR_ADDR[10:3] && !pins.addr[0])
    else $error("attribute write outside config registers");
  reserved_zero_a: assert property (
    !pins.we_n && pins.addr == cap_pkg::COR_ADDR |-> dd_out[5:4] == 2'b00 && dd_oe)
    else $error("reserved index bits driven high");
  upper_lane_a: assert property (
    dd_oe && !op_q[1] |-> dd_out[15:8] == 8'h00)
    else $error("upper lane driven in attribute write");
  pio_select_a: assert property (
    state_q == cap_pkg::ST_ACTIVE && op_q[1] |-> pins.reg_n && pins.even_byte_select_n &&
    pins.task_file_select_low_n != pins.task_file_select_high_n)
    else $error("task file select wrong");
  no_wait_a: assert property (
    $rose(state_q == cap_pkg::ST_ACTIVE) |-> ##[1:40] state_q == cap_pkg::ST_RECOVER)
    else $error("active phase overran");
  cor_shadow_a: assert property (
    state_q == cap_pkg::ST_RECOVER && state_d == cap_pkg::ST_IDLE &&
    op_q == cap_pkg::OP_ATTR_WR && addr_q == cap_pkg::COR_ADDR |=> cor_q == $past(dd_out[7:0]))
    else $error("config shadow not updated");

  attr_read_c: cover property (state_q == cap_pkg::ST_RECOVER && op_q == cap_pkg::OP_ATTR_RD);
  pio_write_c: cover property (state_q == cap_pkg::ST_RECOVER && op_q == cap_pkg::OP_PIO_WR);
  refused_c:   cover property (start && bad);
  cor_write_c: cover property (cor_q != cap_pkg::COR_RESET);
endmodule : cap_host

// ### verif/cap_card_model.sv
`timescale 1ns/10ps
module cap_card_model #(
  parameter logic [7:0] CIS_BYTE = 8'h5A  // Arbitrary identity byte
) (
  // Reset
  input  wire logic               rst_n,
  // Host pins
  input  wire cap_pkg::cap_pins_t pins,
  input  wire logic [15:0]        dd_out,
  input  wire logic               dd_oe,
  output logic      [15:0]        dd_in,
  // Protocol watch
  output logic                    proto_err
);
  logic [7:0]  cor_q;
  logic [15:0] pio_q [16];
  logic [15:0] junk;
  logic [15:0] wdat;
  logic [3:0]  idx;
  logic [7:0]  attr_byte;
  logic        attr_sel;
  logic [2:0]  n_low;
  logic        short_q;
  realtime     t_fall;

  // Undriven lines show a moving pattern, never the last value
  initial junk = 16'h3C3C;
  always #25 junk = {junk[14:0], ~junk[15]};
  assign wdat      = dd_oe ? dd_out : ~dd_out;
  assign attr_sel  = !pins.reg_n && !pins.even_byte_select_n;
  assign idx       = {pins.task_file_select_low_n, pins.device_register_address};
  assign attr_byte = (pins.addr == cap_pkg::COR_ADDR) ? cor_q : CIS_BYTE;
  assign n_low     = 3'(!pins.oe_n) + 3'(!pins.we_n) + 3'(!pins.io_read_strobe_n)
                   + 3'(!pins.io_write_strobe_n);

  // In attribute reads, upper lane and odd addresses carry nothing meaningful
  assign dd_in = !pins.io_read_strobe_n ? pio_q[idx] :
                 (attr_sel && !pins.oe_n && !pins.addr[0]) ? {junk[15:8], attr_byte} :
                 junk;

  // Soft reset clears the rest like a hard reset but keeps itself set
  always @(posedge pins.we_n or negedge rst_n) begin
    if (!rst_n) begin
      cor_q <= 8'h00;
    end else if (attr_sel && !pins.addr[0] && pins.addr == cap_pkg::COR_ADDR) begin
      cor_q <= wdat[7] ? 8'h80 : wdat[7:0];
    end
  end

  // No wait input exists: every strobe length is accepted as given
  always @(posedge pins.io_write_strobe_n) begin
    if (rst_n) begin
      pio_q[idx] <= wdat;
    end
  end

  always @(negedge rst_n or negedge pins.oe_n or negedge pins.we_n
           or negedge pins.io_read_strobe_n or negedge pins.io_write_strobe_n) begin
    if (!rst_n) begin
      proto_err <= 1'b0;
    end else if (n_low > 3'h1) begin
      proto_err <= 1'b1;
    end else if (!pins.we_n && (pins.addr[10:3] != cap_pkg::COR_ADDR[10:3])) begin
      proto_err <= 1'b1;
    end
  end

  // Reported strobe active-time floor is the fastest mode's; narrower data strobes are flagged
  always @(negedge pins.io_read_strobe_n or negedge pins.io_write_strobe_n) begin
    t_fall = $realtime;
  end

  always @(negedge rst_n or posedge pins.io_read_strobe_n or posedge pins.io_write_strobe_n) begin
    if (!rst_n) begin
      short_q <= 1'b0;
    end else if (($realtime - t_fall) < cap_pkg::T2_NS[cap_pkg::NUM_MODES-1]) begin
      short_q <= 1'b1;
    end
  end
endmodule : cap_card_model

// ### verif/test_card_attribute_config_port.sv
`timescale 1ns/10ps
module test_card_attribute_config_port;
  logic               pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic               dd_oe, proto_err, slv;
  logic [7:0]         paddr, e;
  logic [31:0]        pwdata, prdata, rd;
  logic [15:0]        dd_out, dd_in;
  cap_pkg::cap_pins_t pins;
  int                 mismatches, n_compared, cycles, lo_cnt, w_len, k;

  cap_host i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .dd_out(dd_out), .dd_oe(dd_oe), .dd_in(dd_in));
  cap_card_model #(.CIS_BYTE(8'h5A)) i_card (.rst_n(presetn), .pins(pins),
    .dd_out(dd_out), .dd_oe(dd_oe), .dd_in(dd_in), .proto_err(proto_err));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  // Hang guard; tests need well under two thousand cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // Width of each PIO strobe in clocks
  always @(posedge pclk) begin
    if (!pins.io_read_strobe_n || !pins.io_write_strobe_n) begin
      lo_cnt <= lo_cnt + 1;
    end else if (lo_cnt != 0) begin
      w_len  <= lo_cnt;
      lo_cnt <= 0;
    end
  end

  task close_out();
    $display("Counts: compared=%0d mismatches=%0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_compared++;
    if (g !== x) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd  = prdata;
    slv = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Start one card cycle and poll busy until it clears
  task op(input logic [1:0] o, input logic [2:0] m, input logic [10:0] a,
          input logic [15:0] d);
    int i;
    apb(1'b1, cap_pkg::REG_ADDR, {21'h0, a});
    apb(1'b1, cap_pkg::REG_WDATA, {16'h0, d});
    apb(1'b1, cap_pkg::REG_CTRL, {25'h0, m, 2'h0, o});
    i = 0;
    do begin
      apb(1'b0, cap_pkg::REG_STATUS, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 200);
    chk({31'h0, rd[0]}, 32'h0);
  endtask : op

  task rdb(input logic [10:0] a, input logic [31:0] x);
    op(2'h0, 3'h0, a, 16'h0);
    apb(1'b0, cap_pkg::REG_RDATA, 32'h0);
    chk(rd, x);
  endtask : rdb

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    cycles = 0;
    lo_cnt = 0;
    w_len = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    #1;
    chk({9'h0, pins}, {9'h0, cap_pkg::PINS_IDLE});
    apb(1'b0, cap_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'h0);
    rdb(cap_pkg::COR_ADDR, {24'h0, cap_pkg::COR_RESET});
    rdb(11'h000, 32'h5A);
    $display("Reset and identity test done");
    for (k = 0; k < 4; k++) begin
      e = {1'b0, k[0], 4'h0, k[1:0]};
      op(2'h1, 3'h0, cap_pkg::COR_ADDR, {8'hFF, e | 8'h30});
      chk({15'h0, rd[16:8]}, {15'h0, k != 0, e});
      rdb(cap_pkg::COR_ADDR, {24'h0, e});
    end
    $display("Configuration index test done");
    op(2'h1, 3'h0, cap_pkg::COR_ADDR, 16'h00C3);
    rdb(cap_pkg::COR_ADDR, 32'h80);
    op(2'h1, 3'h0, cap_pkg::COR_ADDR, 16'h0000);
    rdb(cap_pkg::COR_ADDR, 32'h00);
    $display("Soft reset test done");
    op(2'h0, 3'h0, 11'h201, 16'h0);
    chk(rd & 32'h3, 32'h2);
    op(2'h1, 3'h0, 11'h002, 16'h0011);
    chk(rd & 32'h3, 32'h2);
    apb(1'b0, cap_pkg::REG_ADDR, 32'h0);
    chk(rd, 32'h002);
    apb(1'b0, cap_pkg::REG_WDATA, 32'h0);
    chk(rd, 32'h0011);
    apb(1'b1, 8'h20, 32'h1);
    chk({31'h0, slv}, 32'h1);
    apb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("Refusal test done");
    for (k = 0; k < 5; k++) begin
      op(2'h3, 3'(k), 11'h00D, 16'hA000 | 16'(k));
      chk(w_len, (cap_pkg::T2_NS[k] + 24) / 25 + 2);
      op(2'h3, 3'(k), 11'h003, 16'h0C30 ^ 16'(k));
      op(2'h2, 3'(k), 11'h00D, 16'h0);
      chk(w_len, (cap_pkg::T2_NS[k] + 24) / 25 + 2);
      apb(1'b0, cap_pkg::REG_RDATA, 32'h0);
      chk(rd, 32'hA000 | k);
      op(2'h2, 3'(k), 11'h003, 16'h0);
      apb(1'b0, cap_pkg::REG_RDATA, 32'h0);
      chk(rd, 32'h0C30 ^ k);
    end
    chk({31'h0, proto_err}, 32'h0);
    chk({31'h0, i_card.short_q}, 32'h0);
    $display("PIO mode test done");
    close_out();
  end
endmodule : test_card_attribute_config_port
